/* urxaf_regs.vh */
/*
 * register offsets, field positions, reset values and sampling constants
 * for the receiver data-recovery and address-filter block.
 * assumes a 32-bit classic wishbone slave, word-aligned byte addresses.
 */
`ifndef URXAF_REGS_VH
`define URXAF_REGS_VH

`define URXAF_ADDR_W 4
`define URXAF_OFF_CTRL_A 4'h0
`define URXAF_OFF_CTRL_C 4'h4
`define URXAF_OFF_DATA 4'h8
`define URXAF_OFF_BAUD 4'hC

// ctrl_status_a bit positions
`define URXAF_A_RXDONE 7
`define URXAF_A_TXDONE 6
`define URXAF_A_TXEMPTY 5
`define URXAF_A_FERR 4
`define URXAF_A_DSPEED 1
`define URXAF_A_AFMODE 0

// ctrl_c bit positions
`define URXAF_C_RXEN 0
`define URXAF_C_TXEN 1
`define URXAF_C_STOP2 2
`define URXAF_C_SIZE_LO 4
`define URXAF_C_SIZE_HI 6
`define URXAF_C_TX9 8
`define URXAF_C_RX9 9

`define URXAF_SIZE_RST 3'h3
`define URXAF_SIZE_9 3'h7
`define URXAF_BAUD_RST 12'h000

// sampling per bit
`define URXAF_SPB_NORM 5'h10
`define URXAF_SPB_DBL 5'h08
`define URXAF_VOTE1_NORM 5'h08
`define URXAF_VOTE1_DBL 5'h04
`define URXAF_VOTE2_NORM 5'h09
`define URXAF_VOTE2_DBL 5'h05

`endif

/* urxaf_top.v */
/*
 * uart receiver data recovery with address filter, plus a minimal
 * transmitter sharing the character size, behind a classic wishbone slave.
 * assumes i_rxd is asynchronous to i_ref_clk and the remote sender keeps
 * its own rules for frame-type bits and stop bits.
 */
// What this block does
// - recovery steps 16 sample states per bit, or eight in double speed.
// - received bit is one when two of three centre samples are high.
// - first voting sample is 8 normally, 4 in double speed.
// - middle voting sample is 9 or 5; third follows it directly.
// - recover bits through the first stop bit; ignore further stop bits.
// - stop bit is voted; a zero vote sets the frame error flag of an accepted frame.
// - next start edge accepted right after last stop voting sample.
// - tolerate incoming rate 95.36 to 104.58 percent, normal speed, D=8.
// - in address-filter mode, data frames are dropped, not buffered.
// - transmit path ignores the address-filter mode bit.
// - for 5 to 8 data bits the first stop bit gives frame type.
// - for nine data bits the ninth data bit gives frame type.
// - frame type one means address, zero means data.
// - in filter mode an address frame is stored and flags done normally.
// - transmitter and receiver share one character size setting.
// - filter mode bit shares a register with the transmit-done flag.
// - double speed cuts sample states per bit from 16 to 8.
// - transmit-done flag clears by writing one to its bit.
`timescale 1ns/1ps
`include "urxaf_regs.vh"

module urxaf_top (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_sel,
  input wire [`URXAF_ADDR_W-1:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // serial line
  input wire i_rxd,
  output reg o_txd
);

  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BITS = 2'h2;

  // control state
  reg afmode;
  reg dspeed;
  reg txdone;
  reg rxen;
  reg txen;
  reg stop2;
  reg [2:0] char_size_sel;
  reg tx9;
  reg [11:0] baud_divisor;
  // receive buffer (one level)
  reg rxdone;
  reg ferr;
  reg [7:0] rx_data;
  reg rx_ninth_bit;

  // synchroniser
  reg rxd_s1;
  reg rxd_s2;

  // baud tick: one pulse per sample period
  // divisor zero gives a tick on every clock
  reg [11:0] baud_cnt;
  reg tick;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      baud_cnt <= 12'h000;
      tick <= 1'b0;
    end else if (baud_cnt == 12'h000) begin
      baud_cnt <= baud_divisor;
      tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt - 12'h001;
      tick <= 1'b0;
    end
  end

  // two stages: i_rxd is asynchronous to the clock
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= i_rxd;
      rxd_s2 <= rxd_s1;
    end
  end

  wire is_nine = (char_size_sel == `URXAF_SIZE_9);
  wire [3:0] ndata = is_nine ? 4'h9 : ({1'b0, char_size_sel} + 4'h5);

  // sample states per bit by speed
  wire [4:0] spb = dspeed ? `URXAF_SPB_DBL : `URXAF_SPB_NORM;
  // centred votes give the rate margin
  wire [4:0] v1 = dspeed ? `URXAF_VOTE1_DBL : `URXAF_VOTE1_NORM;
  wire [4:0] v2 = dspeed ? `URXAF_VOTE2_DBL : `URXAF_VOTE2_NORM;
  wire [4:0] v3 = v2 + 5'h01;

  reg [1:0] rx_state;
  reg [4:0] samp;
  reg [3:0] bit_idx;
  reg [2:0] votes;
  reg [8:0] shift;
  // majority of three
  // third sample is taken live, so the vote lands on its own tick
  wire maj = (votes[0] & votes[1]) | (votes[0] & rxd_s2) | (votes[1] & rxd_s2);
  wire data_last = (bit_idx == ndata);
  reg store;
  reg store_ferr;
  reg store_type;

  always @(posedge i_ref_clk) begin
    // disabling the receiver abandons a frame at once
    if (i_rst || !rxen) begin
      rx_state <= ST_IDLE;
      samp <= 5'h00;
      bit_idx <= 4'h0;
      votes <= 3'h0;
      shift <= 9'h000;
      store <= 1'b0;
      store_ferr <= 1'b0;
      store_type <= 1'b0;
    end else begin
      store <= 1'b0;
      if (tick) begin
        case (rx_state)
          ST_IDLE: begin
            // start edge taken as soon as the previous frame voted its stop
            if (!rxd_s2) begin
              rx_state <= ST_START;
              samp <= 5'h02;
              votes <= 3'h0;
            end
          end
          ST_START: begin
            if (samp == v1) votes[0] <= rxd_s2;
            if (samp == v2) votes[1] <= rxd_s2;
            if (samp == v3) begin
              if (maj) begin
                rx_state <= ST_IDLE;
              end else begin
                rx_state <= ST_BITS;
                bit_idx <= 4'h0;
              end
            end
            samp <= (samp == spb) ? 5'h01 : samp + 5'h01;
            if (samp == spb) votes <= 3'h0;
          end
          ST_BITS: begin
            samp <= (samp == spb) ? 5'h01 : samp + 5'h01;
            if (samp == v1) votes[0] <= rxd_s2;
            if (samp == v2) votes[1] <= rxd_s2;
            if (samp == v3) begin
              // data bits then first stop bit only
              if (!data_last) begin
                shift <= {maj, shift[8:1]};
                bit_idx <= bit_idx + 4'h1;
              end else begin
                // vote stop, then judge type and store
                store <= 1'b1;
                store_ferr <= ~maj;
                store_type <= is_nine ? shift[8] : maj;
                // hunt for next start right after last vote
                rx_state <= ST_IDLE;
              end
            end
          end
          default: rx_state <= ST_IDLE;
        endcase
      end
    end
  end

  // right-align the assembled bits by character size
  reg [8:0] aligned;
  always @* begin
    case (ndata)
      4'h5: aligned = {4'h0, shift[8:4]};
      4'h6: aligned = {3'h0, shift[8:3]};
      4'h7: aligned = {2'h0, shift[8:2]};
      4'h8: aligned = {1'b0, shift[8:1]};
      default: aligned = shift;
    endcase
  end

  // a dropped frame leaves buffer and flags untouched
  // only address frames pass in filter mode
  wire accept = store & (~afmode | store_type);

  // bus decode
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = wb_req & i_wb_we;
  wire rd = wb_req & ~i_wb_we;
  wire sel_a = (i_wb_adr == `URXAF_OFF_CTRL_A);
  wire sel_c = (i_wb_adr == `URXAF_OFF_CTRL_C);
  wire sel_d = (i_wb_adr == `URXAF_OFF_DATA);
  wire sel_b = (i_wb_adr == `URXAF_OFF_BAUD);
  wire rd_data = rd & sel_d;

  // transmitter
  reg [3:0] tx_bits;
  reg [10:0] tx_shift;
  reg tx_busy;
  reg [4:0] tx_samp;
  reg tx_load;
  reg [8:0] tx_word;
  wire tx_end;
  // buffer empties only when the shifter takes the word
  wire tx_start = !tx_busy && tx_load && txen && tick;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rxdone <= 1'b0;
      ferr <= 1'b0;
      rx_data <= 8'h00;
      rx_ninth_bit <= 1'b0;
      afmode <= 1'b0;
      dspeed <= 1'b0;
      txdone <= 1'b0;
      rxen <= 1'b0;
      txen <= 1'b0;
      stop2 <= 1'b0;
      char_size_sel <= `URXAF_SIZE_RST;
      tx9 <= 1'b0;
      baud_divisor <= `URXAF_BAUD_RST;
      tx_load <= 1'b0;
      tx_word <= 9'h000;
    end else begin
      // one-level buffer: a newer accepted frame overwrites
      if (accept) begin
        rxdone <= 1'b1;
        ferr <= store_ferr;
        rx_data <= aligned[7:0];
        rx_ninth_bit <= aligned[8];
      end else if (rd_data || !rxen) begin
        rxdone <= 1'b0;
      end
      if (tx_busy && tx_end && !tx_load) begin
        txdone <= 1'b1;
      end else if (wr && sel_a && i_wb_sel[0] && i_wb_dat[`URXAF_A_TXDONE]) begin
        txdone <= 1'b0;
      end
      if (tx_start) tx_load <= 1'b0;
      if (wr && sel_a && i_wb_sel[0]) begin
        afmode <= i_wb_dat[`URXAF_A_AFMODE];
        dspeed <= i_wb_dat[`URXAF_A_DSPEED];
      end
      if (wr && sel_c) begin
        if (i_wb_sel[0]) begin
          rxen <= i_wb_dat[`URXAF_C_RXEN];
          txen <= i_wb_dat[`URXAF_C_TXEN];
          stop2 <= i_wb_dat[`URXAF_C_STOP2];
          char_size_sel <= i_wb_dat[`URXAF_C_SIZE_HI:`URXAF_C_SIZE_LO];
        end
        if (i_wb_sel[1]) tx9 <= i_wb_dat[`URXAF_C_TX9];
      end
      if (wr && sel_b && i_wb_sel[0]) baud_divisor[7:0] <= i_wb_dat[7:0];
      if (wr && sel_b && i_wb_sel[1]) baud_divisor[11:8] <= i_wb_dat[11:8];
      if (wr && sel_d && i_wb_sel[0] && !tx_load) begin
        tx_load <= 1'b1;
        tx_word <= {tx9, i_wb_dat[7:0]};
      end
    end
  end

  // transmit path has no address-filter term
  assign tx_end = tick && (tx_samp == spb) && (tx_bits == 4'h0);
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_busy <= 1'b0;
      tx_shift <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_samp <= 5'h01;
      o_txd <= 1'b1;
    end else if (!tx_busy) begin
      o_txd <= 1'b1;
      if (tx_start) begin
        tx_busy <= 1'b1;
        tx_samp <= 5'h01;
        o_txd <= 1'b0;
        // data, optional ninth bit, then stop bits, lsb first
        tx_shift <= is_nine ? {2'h3, tx_word} : ({3'h7, tx_word[7:0]}
          | (11'h7FF << ndata));
        tx_bits <= ndata + (stop2 ? 4'h2 : 4'h1);
      end
    end else if (tick) begin
      tx_samp <= (tx_samp == spb) ? 5'h01 : tx_samp + 5'h01;
      if (tx_samp == spb) begin
        if (tx_bits == 4'h0) begin
          tx_busy <= 1'b0;
          o_txd <= 1'b1;
        end else begin
          o_txd <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bits <= tx_bits - 4'h1;
        end
      end
    end
  end

  // wishbone answer one cycle after request
  // writes land on the taking edge, the same edge that raises ack
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h00000000;
      if (rd) begin
        case (i_wb_adr)
          `URXAF_OFF_CTRL_A: o_wb_dat <= {24'h000000, rxdone, txdone, ~tx_load, ferr & rxdone,
            2'h0, dspeed, afmode};
          `URXAF_OFF_CTRL_C: o_wb_dat <= {22'h000000, rx_ninth_bit, tx9, 1'b0,
            char_size_sel, 1'b0, stop2, txen, rxen};
          `URXAF_OFF_DATA: o_wb_dat <= {24'h000000, rx_data};
          `URXAF_OFF_BAUD: o_wb_dat <= {20'h00000, baud_divisor};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

/* urxaf_chk_properties.sv */
/* checker: bus handshake, read-back and transmit line timing at the top ports.
   assumes it is bound to urxaf_top with one clock and synchronous reset. */
`timescale 1ns/1ps
`include "urxaf_regs.vh"
module urxaf_chk (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // bus
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [`URXAF_ADDR_W-1:0] i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  // line
  input wire o_txd
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire rd = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
  a_ack_after_take: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_wb_ack && o_txd && o_wb_dat == 0)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (rd && i_wb_adr[1:0] != 0 |=> o_wb_dat == 0)
    else $error("unmapped read not zero");
  a_status_spare: assert property (rd && i_wb_adr == 4'h0 |=>
    o_wb_dat[31:8] == 0 && o_wb_dat[3:2] == 0) else $error("status spare bits set");
  a_ctrl_spare: assert property (rd && i_wb_adr == 4'h4 |=>
    o_wb_dat[31:10] == 0 && !o_wb_dat[7] && !o_wb_dat[3])
    else $error("control spare bits set");
  a_start_len: assert property ($fell(o_txd) |-> (!o_txd) [*8])
    else $error("start bit too short");
  c_read: cover property (rd && i_wb_adr == 4'h8);
  c_unmapped: cover property (rd && i_wb_adr[1:0] != 0);
  c_tx_start: cover property ($fell(o_txd));
endmodule

bind urxaf_top urxaf_chk chk_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_txd(o_txd));

/* urxaf_sender.sv */
/* remote serial sender on the receive line.
   the line idles high, driven high by the sender between frames. */
`timescale 1ns/1ps
module urxaf_sender (
  // line
  output logic o_line
);
  initial o_line = 1'b1;
  // type bit sent as ninth bit or first stop
  task automatic send(input logic [9:0] b, input int n, input real bn, input real ln,
    input real ga, input real gl);
    // launch off the clock edge so the synchroniser sees no race
    #(3);
    o_line = 1'b0;
    #(bn);
    for (int i = 0; i < n; i++) begin
      o_line = b[i];
      // spike inside the first data bit to probe the vote
      if (i == 0 && gl > 0) begin
        #(ga) o_line = !b[0];
        #(gl) o_line = b[0];
        #(bn - ga - gl);
      end else begin
        #((i == n - 1) ? ln : bn);
      end
    end
    o_line = 1'b1;
  endtask
endmodule

/* testbench.sv */
/* self-checking bench for the receive recovery and address filter block.
   assumes bus answers in one cycle and divisor zero gives 16 clocks a bit. */
`timescale 1ns/1ps
`include "urxaf_regs.vh"
module testbench;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0] sel = 4'hF;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic ack, txd, rxd, n9;
  logic [8:0] v;
  int n_mismatch = 0, num_checks = 0, cyc_cnt = 0;
  always #10 clk = ~clk;
  urxaf_top dut_u (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_sel(sel), .i_wb_adr(adr), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_rxd(rxd), .o_txd(txd));
  urxaf_sender peer_u (.o_line(rxd));
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rx(input logic [9:0] b, input int n, input real bn, input real ln,
    input real ga, input real gl, input logic dn, input logic [8:0] d, input logic fe);
    peer_u.send(b, n, bn, ln, ga, gl);
    repeat (4) @(posedge clk);
    acc(0, 4'h4, 0);
    n9 = q[9];
    acc(0, 4'h0, 0);
    chk("rx_done_flag", dn, q[7]);
    if (dn) begin
      chk("frame_error_flag", fe, q[4]);
      if (n == 10) chk("rx_ninth_bit", d[8], n9);
      acc(0, 4'h8, 0);
      chk("rx data", d[7:0], q[7:0]);
    end
  endtask
  task automatic t_regs;
    acc(0, 4'h0, 0);
    chk("ctrl_status_a reset", 32'h20, q);
    acc(0, 4'h4, 0);
    chk("ctrl_c reset", 32'h30, q);
    acc(0, 4'hC, 0);
    chk("baud_divisor reset", 32'h0, q);
    acc(1, 4'h1, 32'hFF);
    acc(0, 4'h1, 0);
    chk("unmapped", 32'h0, q);
    acc(1, 4'h4, 32'h33);
    acc(0, 4'h4, 0);
    chk("ctrl_c", 32'h33, q);
  endtask
  task automatic t_rx;
    rx({1'b1, 8'hA5}, 9, 320, 320, 0, 0, 1, 9'h0A5, 0);
    rx({1'b0, 8'h3C}, 9, 320, 320, 0, 0, 1, 9'h03C, 1);
    rx({1'b1, 8'h5A}, 9, 320, 320, 160, 20, 1, 9'h05A, 0);
    rx({1'b1, 8'h5A}, 9, 320, 320, 150, 60, 1, 9'h05B, 0);
    rx({1'b1, 8'h96}, 9, 320 / 1.03, 320, 0, 0, 1, 9'h096, 0);
    rx({1'b1, 8'h69}, 9, 320 / 0.97, 320, 0, 0, 1, 9'h069, 0);
    peer_u.send({1'b1, 8'hF0}, 9, 320, 240, 0, 0);
    rx({1'b1, 8'h81}, 9, 320, 320, 0, 0, 1, 9'h081, 0);
    acc(1, 4'h0, 32'h02);
    rx({1'b1, 8'hE7}, 9, 160, 160, 0, 0, 1, 9'h0E7, 0);
    acc(1, 4'h0, 32'h01);
    rx({1'b0, 8'h11}, 9, 320, 320, 0, 0, 0, 9'h011, 0);
    rx({1'b1, 8'h22}, 9, 320, 320, 0, 0, 1, 9'h022, 0);
    acc(1, 4'h4, 32'h73);
    rx({1'b1, 9'h033}, 10, 320, 320, 0, 0, 0, 9'h033, 0);
    rx({1'b1, 9'h144}, 10, 320, 320, 0, 0, 1, 9'h144, 0);
    acc(1, 4'h0, 32'h00);
    rx({1'b1, 9'h055}, 10, 320, 320, 0, 0, 1, 9'h055, 0);
    acc(1, 4'h4, 32'h33);
  endtask
  task automatic t_tx;
    acc(1, 4'h0, 32'h01);
    acc(1, 4'h8, 32'hC3);
    @(negedge txd);
    #(160);
    for (int i = 0; i < 9; i++) begin
      #(320) v[i] = txd;
    end
    chk("tx frame", 9'h1C3, v);
    for (int i = 0; i < 50 && q[6] !== 1'b1; i++) acc(0, 4'h0, 0);
    chk("tx_done_flag set", 1, q[6]);
    acc(1, 4'h0, 32'h41);
    acc(0, 4'h0, 0);
    chk("tx_done_flag clear", 32'h01, q & 32'h41);
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_rx;
    t_tx;
    tally_and_finish;
  end
endmodule
